// ===== tcom_timer_capture.v
// timer capture and operating-mode block with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "tcom_defines.vh"
module tcom_timer_capture #(
  parameter CNT_W = 16
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire capture_input_a_in,
  input wire capture_input_b_in,
  output reg timer_output_pin_out,
  output reg irq_out
);
  // ==========================================
  // edge decode helpers
  function edge_hit;
    input [1:0] sel;
    input rise;
    input fall;
    begin
      case (sel)
        `TCOM_EDGE_FALL: edge_hit = fall;
        `TCOM_EDGE_RISE: edge_hit = rise;
        `TCOM_EDGE_BOTH: edge_hit = rise | fall;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  function [1:0] opp_sel;
    input [1:0] sel;
    begin
      case (sel)
        `TCOM_EDGE_FALL: opp_sel = `TCOM_EDGE_RISE;
        `TCOM_EDGE_RISE: opp_sel = `TCOM_EDGE_FALL;
        default: opp_sel = sel;
      endcase
    end
  endfunction

  function new_level;
    input [2:0] samp;
    input stable;
    begin
      new_level = (samp[1] == samp[2]) & (samp[1] != stable);
    end
  endfunction

  // ==========================================
  // registers
  reg [3:0] timer_mode_control;
  reg [7:0] cap_ctl;
  reg [1:0] count_clock_select_reg;
  reg [CNT_W-1:0] timer_counter_value;
  reg [CNT_W-1:0] capture_compare_reg_a;
  reg [CNT_W-1:0] capture_compare_reg_b;
  reg [`TCOM_NIRQ-1:0] irq_status;
  reg [`TCOM_NIRQ-1:0] irq_enable;
  reg [2:0] presc;
  reg [2:0] samp_a;
  reg [2:0] samp_b;
  reg stable_a;
  reg stable_b;

  wire [1:0] op_mode;
  wire running;
  wire acc;
  wire wr_ok;
  wire [1:0] sel_a;
  wire [1:0] sel_b;
  reg tick;
  reg hit_map;

  assign op_mode = timer_mode_control[`TCOM_MODE_HI:`TCOM_MODE_LO];
  assign running = (op_mode != `TCOM_OP_STOP);
  assign acc = psel_in & penable_in;
  assign wr_ok = acc & pready_out & pwrite_in & ~pslverr_out;
  assign sel_a = cap_ctl[`TCOM_EDGE_A_HI:`TCOM_EDGE_A_LO];
  assign sel_b = cap_ctl[`TCOM_EDGE_B_HI:`TCOM_EDGE_B_LO];

  // ==========================================
  // count clock enable from prescaler
  always @* begin
    case (count_clock_select_reg)
      `TCOM_DIV_1: tick = 1'b1;
      `TCOM_DIV_2: tick = presc[0];
      `TCOM_DIV_4: tick = &presc[1:0];
      default: tick = &presc;
    endcase
  end

  // ==========================================
  // input sampling and edge detection
  wire a_new;
  wire b_new;
  wire rise_a;
  wire fall_a;
  wire rise_b;
  wire fall_b;
  // a new level counts only when two consecutive samples agree
  assign a_new = tick & running & new_level(samp_a, stable_a);
  assign b_new = tick & running & new_level(samp_b, stable_b);
  assign rise_a = a_new & samp_a[1];
  assign fall_a = a_new & ~samp_a[1];
  assign rise_b = b_new & samp_b[1];
  assign fall_b = b_new & ~samp_b[1];

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      samp_a <= 3'h0;
      samp_b <= 3'h0;
      stable_a <= 1'b0;
      stable_b <= 1'b0;
    end else if (tick) begin
      samp_a <= {samp_a[1:0], capture_input_a_in};
      samp_b <= {samp_b[1:0], capture_input_b_in};
      if (a_new) begin
        stable_a <= samp_a[1];
      end
      if (b_new) begin
        stable_b <= samp_b[1];
      end
    end
  end

  // ==========================================
  // capture triggers
  wire opp;
  wire trig_a;
  wire trig_b;
  wire ext_b;
  wire ovf;
  wire hit_b;
  assign opp = cap_ctl[`TCOM_CAP_A_OPP];
  assign hit_b = edge_hit(sel_b, rise_b, fall_b);
  // normal: register a takes input b edge; opposite phase: input a reverse edge
  assign trig_a = cap_ctl[`TCOM_CAP_A_EN] & (opp ?
    edge_hit(opp_sel(sel_a), rise_a, fall_a) : hit_b);
  assign ext_b = opp & hit_b;
  assign trig_b = cap_ctl[`TCOM_CAP_B_EN] & edge_hit(sel_a, rise_a, fall_a);
  assign ovf = tick & running & (&timer_counter_value);

  // ==========================================
  // counter and capture registers
  reg [2:0] next_presc;
  reg [CNT_W-1:0] next_count;
  reg [CNT_W-1:0] next_cap_a;
  reg [CNT_W-1:0] next_cap_b;
  reg next_out_pin;
  // stop clears counter and prescaler
  always @* begin
    next_presc = 3'h0;
    next_count = {CNT_W{1'b0}};
    next_cap_a = capture_compare_reg_a;
    next_cap_b = capture_compare_reg_b;
    next_out_pin = timer_output_pin_out;
    if (running) begin
      next_presc = presc + 3'h1;
      next_count = timer_counter_value;
      if (tick) begin
        next_count = timer_counter_value + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
    if (trig_a) begin
      next_cap_a = timer_counter_value;
    end
    if (trig_b) begin
      next_cap_b = timer_counter_value;
    end
    if (ovf & timer_mode_control[`TCOM_MODE_OUTEN]) begin
      next_out_pin = ~timer_output_pin_out;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      timer_counter_value <= {CNT_W{1'b0}};
      capture_compare_reg_a <= {CNT_W{1'b0}};
      capture_compare_reg_b <= {CNT_W{1'b0}};
      timer_output_pin_out <= 1'b0;
      presc <= 3'h0;
    end else begin
      timer_counter_value <= next_count;
      capture_compare_reg_a <= next_cap_a;
      capture_compare_reg_b <= next_cap_b;
      timer_output_pin_out <= next_out_pin;
      presc <= next_presc;
    end
  end

  // ==========================================
  // interrupt status, set wins over clear
  reg [`TCOM_NIRQ-1:0] ev;
  reg [`TCOM_NIRQ-1:0] clr;
  reg [`TCOM_NIRQ-1:0] next_status;
  reg next_irq;
  always @* begin
    ev = {`TCOM_NIRQ{1'b0}};
    ev[`TCOM_IRQ_A] = (trig_a & ~opp) | ext_b;
    ev[`TCOM_IRQ_B] = trig_b;
    ev[`TCOM_IRQ_OVF] = ovf;
    clr = {`TCOM_NIRQ{1'b0}};
    if (wr_ok && paddr_in == `TCOM_OFS_CLEAR) begin
      clr = pwdata_in[`TCOM_NIRQ-1:0];
    end
    next_status = (irq_status & ~clr) | ev;
    next_irq = |(next_status & irq_enable);
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_status <= `TCOM_RST_IRQ;
      irq_out <= 1'b0;
    end else begin
      irq_status <= next_status;
      irq_out <= next_irq;
    end
  end

  // ==========================================
  // apb decode
  always @* begin
    case (paddr_in)
      `TCOM_OFS_MODE, `TCOM_OFS_CAPCTL, `TCOM_OFS_CLKSEL, `TCOM_OFS_COUNT,
      `TCOM_OFS_CCR_A, `TCOM_OFS_CCR_B, `TCOM_OFS_STATUS, `TCOM_OFS_CLEAR,
      `TCOM_OFS_ENABLE: hit_map = 1'b1;
      default: hit_map = 1'b0;
    endcase
  end

  reg [31:0] rd;
  always @* begin
    rd = 32'h0000_0000;
    case (paddr_in)
      `TCOM_OFS_MODE: rd[3:0] = timer_mode_control;
      `TCOM_OFS_CAPCTL: rd[7:0] = cap_ctl;
      `TCOM_OFS_CLKSEL: rd[1:0] = count_clock_select_reg;
      `TCOM_OFS_COUNT: rd[CNT_W-1:0] = timer_counter_value;
      `TCOM_OFS_CCR_A: rd[CNT_W-1:0] = capture_compare_reg_a;
      `TCOM_OFS_CCR_B: rd[CNT_W-1:0] = capture_compare_reg_b;
      `TCOM_OFS_STATUS: rd[`TCOM_NIRQ-1:0] = irq_status;
      `TCOM_OFS_ENABLE: rd[`TCOM_NIRQ-1:0] = irq_enable;
      default: rd = 32'h0000_0000;
    endcase
  end

  // ==========================================
  // apb answer: one wait state, then pready
  reg next_ready;
  reg next_err;
  reg [31:0] next_rdata;
  always @* begin
    next_ready = 1'b0;
    next_err = 1'b0;
    next_rdata = 32'h0000_0000;
    if (acc & ~pready_out) begin
      next_ready = 1'b1;
      next_err = ~hit_map;
      next_rdata = pwrite_in ? 32'h0000_0000 : rd;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= next_ready;
      pslverr_out <= next_err;
      prdata_out <= next_rdata;
    end
  end

  // ==========================================
  // register writes
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      timer_mode_control <= `TCOM_RST_MODE;
      cap_ctl <= `TCOM_RST_CAPCTL;
      count_clock_select_reg <= `TCOM_RST_CLKSEL;
      irq_enable <= `TCOM_RST_IRQ;
    end else if (wr_ok) begin
      case (paddr_in)
        `TCOM_OFS_MODE: timer_mode_control <= pwdata_in[3:0];
        `TCOM_OFS_CAPCTL: cap_ctl <= pwdata_in[7:0];
        `TCOM_OFS_CLKSEL: count_clock_select_reg <= pwdata_in[1:0];
        `TCOM_OFS_ENABLE: irq_enable <= pwdata_in[`TCOM_NIRQ-1:0];
        default: irq_enable <= irq_enable;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== tcom_defines.vh
// constants for the timer capture and operating-mode block
// Notes on behaviour
// - opposite-phase capture into register a raises no capture interrupt
// - opposite-phase mode: input b edge captures nothing, raises capture interrupt
// - counter starts as soon as the mode field is written non-zero
// - writing zero to the mode field stops the counter
`ifndef TCOM_DEFINES_VH
`define TCOM_DEFINES_VH
// ==========================================
// register byte offsets
`define TCOM_OFS_MODE 8'h00
`define TCOM_OFS_CAPCTL 8'h04
`define TCOM_OFS_CLKSEL 8'h08
`define TCOM_OFS_COUNT 8'h0c
`define TCOM_OFS_CCR_A 8'h10
`define TCOM_OFS_CCR_B 8'h14
`define TCOM_OFS_STATUS 8'h18
`define TCOM_OFS_CLEAR 8'h1c
`define TCOM_OFS_ENABLE 8'h20
// ==========================================
// field positions
`define TCOM_MODE_LO 2
`define TCOM_MODE_HI 3
`define TCOM_MODE_CAPSEL 1
`define TCOM_MODE_OUTEN 0
`define TCOM_CAP_B_EN 0
`define TCOM_CAP_A_EN 1
`define TCOM_CAP_A_OPP 2
`define TCOM_EDGE_A_LO 4
`define TCOM_EDGE_A_HI 5
`define TCOM_EDGE_B_LO 6
`define TCOM_EDGE_B_HI 7
`define TCOM_IRQ_A 0
`define TCOM_IRQ_B 1
`define TCOM_IRQ_OVF 2
// ==========================================
// encodings and reset values
`define TCOM_OP_STOP 2'h0
`define TCOM_EDGE_FALL 2'h0
`define TCOM_EDGE_RISE 2'h1
`define TCOM_EDGE_BOTH 2'h3
`define TCOM_DIV_1 2'h0
`define TCOM_DIV_2 2'h1
`define TCOM_DIV_4 2'h2
`define TCOM_RST_MODE 4'h0
`define TCOM_RST_CAPCTL 8'h00
`define TCOM_RST_CLKSEL 2'h0
`define TCOM_RST_IRQ 3'h0
`define TCOM_NIRQ 3
`endif

// ===== tcom_chk_chk.sv
// port checker for the timer capture block
`timescale 1ns/1ps
`default_nettype none
module tcom_chk (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic capture_input_a_in,
  input wire logic capture_input_b_in,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================
  // bus access
  sequence s_wait;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence s_done;
    pready_out ##1 !pready_out;
  endsequence
  chk_ready_wait: assert property (s_wait |=> s_done) else $error("ready not one pulse");
  chk_ready_alone: assert property (pready_out |-> psel_in && penable_in) else $error("stray ready");
  chk_err_ready: assert property (pslverr_out |-> pready_out) else $error("error without ready");
  chk_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0) else $error("rdata not 0");
  // ==========================================
  // trigger filtering
  chk_edge_a: assert property ($changed(capture_input_a_in) |=> !$rose(irq_out))
    else $error("pin a acted on one sample");
  chk_edge_b: assert property ($changed(capture_input_b_in) |=> !$rose(irq_out))
    else $error("pin b acted on one sample");
endmodule
bind tcom_timer_capture tcom_chk chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out),
  .capture_input_a_in(capture_input_a_in), .capture_input_b_in(capture_input_b_in));
`default_nettype wire

// ===== tcom_trig_model.sv
// trigger pin model for the two capture inputs
`timescale 1ns/1ps
`default_nettype none
module tcom_trig_model (
  input wire logic clk_in,
  output var logic pin_a_out,
  output var logic pin_b_out
);
  initial begin
    pin_a_out = 1'b0;
    pin_b_out = 1'b0;
  end
  // high pulse of w clocks on one pin, idle low
  task automatic pulse(input logic on_b, input int w);
    @(posedge clk_in);
    pin_a_out <= !on_b;
    pin_b_out <= on_b;
    repeat (w) @(posedge clk_in);
    pin_a_out <= 1'b0;
    pin_b_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== timer_capture_operating_mode_bench.sv
// testbench for the timer capture block
`timescale 1ns/1ps
`default_nettype none
`include "tcom_defines.vh"
module timer_capture_operating_mode_bench;
  logic clk_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, err;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd, ccr;
  logic pready_out, pslverr_out, cap_a, cap_b, irq_out, tout;
  int n_fail = 0, num_checks = 0, cyc = 0;
  tcom_timer_capture uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .capture_input_a_in(cap_a), .capture_input_b_in(cap_b),
    .timer_output_pin_out(tout), .irq_out(irq_out));
  tcom_trig_model trig (.clk_in(clk_in), .pin_a_out(cap_a), .pin_b_out(cap_b));
  initial forever #25 clk_in = ~clk_in;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    apb(0, `TCOM_OFS_MODE, 0);
    chk(rd, 0, "mode reset");
    apb(0, 8'h24, 0);
    chk({31'h0, err}, 1, "unmapped error");
    apb(1, `TCOM_OFS_MODE, 32'h4);
    apb(0, `TCOM_OFS_COUNT, 0);
    chk(rd != 0, 1, "count runs");
    apb(1, `TCOM_OFS_MODE, 0);
    apb(0, `TCOM_OFS_COUNT, 0);
    chk(rd, 0, "count stopped");
    apb(1, `TCOM_OFS_ENABLE, 32'h7);
    apb(1, `TCOM_OFS_CAPCTL, 32'h11);
    apb(1, `TCOM_OFS_MODE, 32'h4);
    trig.pulse(0, 5);
    repeat (8) @(posedge clk_in);
    apb(0, `TCOM_OFS_STATUS, 0);
    chk(rd, 2, "capture b status");
    chk(irq_out, 1, "irq line");
    apb(0, `TCOM_OFS_CCR_B, 0);
    chk(rd != 0, 1, "reg b captured");
    apb(1, `TCOM_OFS_CLEAR, 32'h2);
    trig.pulse(0, 1);
    repeat (8) @(posedge clk_in);
    apb(0, `TCOM_OFS_STATUS, 0);
    chk(rd, 0, "glitch ignored");
    chk(irq_out, 0, "irq cleared");
    apb(1, `TCOM_OFS_CAPCTL, 32'h56);
    trig.pulse(0, 5);
    repeat (8) @(posedge clk_in);
    apb(0, `TCOM_OFS_STATUS, 0);
    chk(rd, 0, "opposite no irq");
    apb(0, `TCOM_OFS_CCR_A, 0);
    ccr = rd;
    chk(ccr != 0, 1, "reg a captured");
    trig.pulse(1, 5);
    repeat (8) @(posedge clk_in);
    apb(0, `TCOM_OFS_STATUS, 0);
    chk(rd, 1, "pin b irq");
    chk(irq_out, 1, "pin b irq line");
    apb(0, `TCOM_OFS_CCR_A, 0);
    chk(rd, ccr, "reg a held");
    apb(1, `TCOM_OFS_ENABLE, 0);
    repeat (2) @(posedge clk_in);
    chk(irq_out, 0, "irq masked");
    apb(1, `TCOM_OFS_CLEAR, 32'h7);
    apb(1, `TCOM_OFS_CLKSEL, 32'h1);
    apb(1, `TCOM_OFS_CAPCTL, 32'he2);
    trig.pulse(1, 8);
    repeat (16) @(posedge clk_in);
    apb(0, `TCOM_OFS_STATUS, 0);
    chk(rd, 1, "edge b irq a");
    apb(0, `TCOM_OFS_CCR_A, 0);
    chk(rd != ccr, 1, "reg a on edge b");
    apb(0, `TCOM_OFS_CLKSEL, 0);
    chk(rd, 1, "clksel readback");
    apb(0, `TCOM_OFS_CLEAR, 0);
    chk(rd, 0, "clear reads 0");
    chk(tout, 0, "output pin idle");
    give_verdict();
  end
endmodule
`default_nettype wire
